// *** pcf_pkg.sv ***
// Shared constants, types and register map of the programming input calibration controller.
`default_nettype none
package pcf_pkg;
    localparam int VAL_W = 16;
    // Time base: one internal tick per millisecond.
    localparam int CLK_PERIOD_NS = 25;
    localparam int T_TICK_NS = 1000000;
    localparam int TICK_CYC = (T_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICKS_PER_S = 1000;
    localparam int T_ENTRY_S = 4;
    localparam int T_CAPTURE_S = 2;
    localparam int T_SHORT_S = 1;
    localparam int T_IDLE_MIN = 10;
    localparam int T_DEBOUNCE_MS = 20;
    localparam int ENTRY_TICKS = T_ENTRY_S * TICKS_PER_S;
    localparam int CAPTURE_TICKS = T_CAPTURE_S * TICKS_PER_S;
    localparam int SHORT_TICKS = T_SHORT_S * TICKS_PER_S;
    localparam int IDLE_TICKS = T_IDLE_MIN * 60 * TICKS_PER_S;
    localparam int DEBOUNCE_TICKS = T_DEBOUNCE_MS * TICKS_PER_S / 1000;
    // Factory calibration.
    localparam logic [VAL_W-1:0] OUT_MIN = 16'h0000;
    localparam logic [VAL_W-1:0] OUT_MAX = 16'hFFFF;
    localparam logic [VAL_W-1:0] ADJ_STEP = 16'h0040;
    localparam logic CUR_VARIANT_RST = 1'b1;
    // Register byte offsets.
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_NULL = 8'h08;
    localparam logic [7:0] REG_END = 8'h0C;
    localparam logic [7:0] REG_START_VAL = 8'h10;
    localparam logic [7:0] REG_END_VAL = 8'h14;
    localparam int CTRL_CUR_VARIANT = 0;
    typedef enum logic [1:0] {PCF_NORMAL, PCF_TEACH, PCF_ADJUST, PCF_RESET} pcf_mode_t;
    typedef enum logic [1:0] {PCF_OUT_LIVE, PCF_OUT_TEACH_IND, PCF_OUT_ADJ_IND, PCF_OUT_ERROR} pcf_out_sel_t;
    typedef struct packed {
        logic [VAL_W-1:0] null_pt;
        logic [VAL_W-1:0] end_pt;
        logic [VAL_W-1:0] start_val;
        logic [VAL_W-1:0] end_val;
        logic invert;
    } pcf_cal_t;
    localparam pcf_cal_t CAL_FACTORY = '{OUT_MIN, OUT_MAX, OUT_MIN, OUT_MAX, 1'b0};
endpackage : pcf_pkg
`default_nettype wire

// *** pcf_calib.sv ***
// Programming input calibration controller: hold timing, teach-in, adjust, invert and reset.
// Functional notes
// [R1] Settings change only via the two programming inputs; high means active.
// [R2] Programming mode ends after about ten minutes without input activity.
// [R3] Calibration values persist whether the session ended by inputs or timeout.
// [R4] The operator must not reverse null and end points.
// [R5] The operator keeps null and end points within the output span.
// [R6] Input a alone for four seconds enters teach-in with its indication value.
// [R7] After the entry indication, live position returns once the input is released.
// [R8] In teach-in, a held two seconds stores position as null point.
// [R9] In teach-in, b held two seconds stores position as end point.
// [R10] Capturing one point leaves the other point unchanged.
// [R11] Both held four seconds in teach-in inverts the curve on release.
// [R12] While both are held for inversion the output shows the error value.
// [R13] Inversion affects only the current output of current variants.
// [R14] Both briefly under one second ends teach-in, error shown during the press.
// [R15] Setting steps come in any order and the session may end anytime.
// [R16] Adjust mode captures start and end points and trims their values.
// [R17] Reset restores every calibration setting to factory default.
// [R18] Input b alone for four seconds enters adjust with its indication value.
// [R19] In adjust, a held two seconds sets start point keeping last start value.
// [R20] Both held four seconds starts reset; completing it clears values.
// [R21] A brief both press after reset activation aborts without changes.
// [R22] Hold times come from a clock-derived tick, after debouncing both inputs.
// [R23] Both active together is one command; single-input commands are then ignored.
`timescale 1ns/100ps
`default_nettype none
module pcf_calib #(
    parameter int TICK_CYC = pcf_pkg::TICK_CYC,
    parameter int IDLE_TICKS = pcf_pkg::IDLE_TICKS,
    parameter int ENTRY_TICKS = pcf_pkg::ENTRY_TICKS,
    parameter int CAPTURE_TICKS = pcf_pkg::CAPTURE_TICKS,
    parameter int SHORT_TICKS = pcf_pkg::SHORT_TICKS,
    parameter int DEBOUNCE_TICKS = pcf_pkg::DEBOUNCE_TICKS
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic program_input_a,
    input wire logic program_input_b,
    input wire logic [pcf_pkg::VAL_W-1:0] position,
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output pcf_pkg::pcf_out_sel_t out_sel,
    output pcf_pkg::pcf_cal_t cal,
    output logic current_invert,
    output logic prog_active
);
    ////////////////////////////////////////////////////////////////////////////
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [1:0] deb;
    logic [31:0] tick_cnt;
    logic tick;
    logic [31:0] hold_cnt;
    logic [31:0] idle_cnt;
    logic both_seen;
    logic press_q;
    logic ind_hold;
    logic inv_pend;
    logic adj_end_sel;
    logic cur_variant;
    pcf_pkg::pcf_mode_t mode;
    logic [1:0] pin_prev;

    wire logic press = |deb;
    wire logic both = &deb;
    wire logic a_only = (deb == 2'b01) && !both_seen;
    wire logic b_only = (deb == 2'b10) && !both_seen;
    wire logic fire_cap = tick && press && (hold_cnt == 32'(CAPTURE_TICKS - 1));
    wire logic fire_entry = tick && press && (hold_cnt == 32'(ENTRY_TICKS - 1));
    wire logic release_ev = press_q && !press;
    wire logic rel_short = release_ev && (hold_cnt < 32'(SHORT_TICKS));
    wire logic short_both = rel_short && both_seen;
    wire logic short_a = rel_short && !both_seen && (pin_prev == 2'b01);
    wire logic short_b = rel_short && !both_seen && (pin_prev == 2'b10);
    wire logic timeout = tick && (mode != pcf_pkg::PCF_NORMAL) && (idle_cnt == 32'(IDLE_TICKS - 1));

    ////////////////////////////////////////////////////////////////////////////
    // Timebase: a slow tick keeps the multi-second hold counts small, though the counters are 32 bits wide.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            tick_cnt <= '0;
            tick <= 1'b0;
        end
        else
        begin
            tick <= (tick_cnt == 32'(TICK_CYC - 1));
            tick_cnt <= (tick_cnt == 32'(TICK_CYC - 1)) ? '0 : tick_cnt + 32'd1;
        end
    end

    // Pins are asynchronous; each passes two flops, then a tick-based stability filter.
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_pin
            logic [31:0] deb_cnt;
            always_ff @(posedge mclk or posedge rst)
            begin
                if (rst)
                begin
                    pin_s1[gi] <= 1'b0;
                    pin_s2[gi] <= 1'b0;
                    deb[gi] <= 1'b0;
                    deb_cnt <= '0;
                end
                else
                begin
                    pin_s1[gi] <= (gi == 0) ? program_input_a : program_input_b; // [R1]
                    pin_s2[gi] <= pin_s1[gi];
                    if (pin_s2[gi] == deb[gi])
                        deb_cnt <= '0;
                    else if (tick)
                    begin
                        if (deb_cnt == 32'(DEBOUNCE_TICKS - 1))
                        begin
                            deb[gi] <= pin_s2[gi]; // [R22]
                            deb_cnt <= '0;
                        end
                        else
                            deb_cnt <= deb_cnt + 32'd1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Press tracking: hold time and whether both inputs overlapped in this press.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            hold_cnt <= '0;
            both_seen <= 1'b0;
            press_q <= 1'b0;
            pin_prev <= 2'b00;
        end
        else
        begin
            press_q <= press;
            if (press)
                pin_prev <= deb | (both_seen ? 2'b11 : 2'b00);
            if (!press)
            begin
                hold_cnt <= '0;
                both_seen <= 1'b0;
            end
            else
            begin
                if (both)
                    both_seen <= 1'b1; // [R23]
                if (tick && hold_cnt < 32'(ENTRY_TICKS))
                    hold_cnt <= hold_cnt + 32'd1; // [R22]
            end
        end
    end

    // Any input activity restarts the inactivity timer.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            idle_cnt <= '0;
        else if (press || mode == pcf_pkg::PCF_NORMAL || timeout)
            idle_cnt <= '0;
        else if (tick)
            idle_cnt <= idle_cnt + 32'd1; // [R2]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode sequencing; steps inside a mode may be taken in any order.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            mode <= pcf_pkg::PCF_NORMAL;
            ind_hold <= 1'b0;
        end
        else
        begin
            if (release_ev)
                ind_hold <= 1'b0; // [R7]
            if (timeout)
                mode <= pcf_pkg::PCF_NORMAL; // [R2] [R3]
            else
            begin
                unique case (mode)
                    pcf_pkg::PCF_NORMAL:
                    begin
                        if (fire_entry && a_only)
                        begin
                            mode <= pcf_pkg::PCF_TEACH; // [R6]
                            ind_hold <= 1'b1;
                        end
                        else if (fire_entry && b_only)
                        begin
                            mode <= pcf_pkg::PCF_ADJUST; // [R18]
                            ind_hold <= 1'b1;
                        end
                        else if (fire_entry && both)
                            mode <= pcf_pkg::PCF_RESET; // [R20]
                    end
                    pcf_pkg::PCF_TEACH, pcf_pkg::PCF_ADJUST:
                        if (short_both)
                            mode <= pcf_pkg::PCF_NORMAL; // [R14] [R15]
                    pcf_pkg::PCF_RESET:
                        if (short_both || (fire_entry && both))
                            mode <= pcf_pkg::PCF_NORMAL; // [R20] [R21]
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Calibration store; only the programming inputs change it, so values persist.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            cal <= pcf_pkg::CAL_FACTORY;
            inv_pend <= 1'b0;
            adj_end_sel <= 1'b0;
        end
        else
        begin
            if (mode == pcf_pkg::PCF_TEACH && !ind_hold)
            begin
                if (fire_cap && a_only)
                    cal.null_pt <= position; // [R8] [R10]
                if (fire_cap && b_only)
                    cal.end_pt <= position; // [R9] [R10]
                if (fire_entry && both)
                    inv_pend <= 1'b1; // [R11]
            end
            if (inv_pend && release_ev)
            begin
                cal.invert <= !cal.invert; // [R11]
                inv_pend <= 1'b0;
            end
            if (mode == pcf_pkg::PCF_ADJUST && !ind_hold)
            begin
                if (fire_cap && a_only)
                begin
                    cal.null_pt <= position; // [R19]
                    adj_end_sel <= 1'b0;
                end
                if (fire_cap && b_only)
                begin
                    cal.end_pt <= position; // [R16]
                    adj_end_sel <= 1'b1;
                end
                if (short_b && !adj_end_sel)
                    cal.start_val <= trim_up(cal.start_val); // [R16]
                if (short_a && !adj_end_sel)
                    cal.start_val <= trim_down(cal.start_val);
                if (short_b && adj_end_sel)
                    cal.end_val <= trim_up(cal.end_val);
                if (short_a && adj_end_sel)
                    cal.end_val <= trim_down(cal.end_val);
            end
            if (mode == pcf_pkg::PCF_RESET && fire_entry && both)
                cal <= pcf_pkg::CAL_FACTORY; // [R17] [R20]
        end
    end

    // Trims saturate at the output limits instead of wrapping.
    function automatic logic [pcf_pkg::VAL_W-1:0] trim_up(input logic [pcf_pkg::VAL_W-1:0] v);
        trim_up = (v > pcf_pkg::OUT_MAX - pcf_pkg::ADJ_STEP) ? pcf_pkg::OUT_MAX : v + pcf_pkg::ADJ_STEP;
    endfunction : trim_up

    function automatic logic [pcf_pkg::VAL_W-1:0] trim_down(input logic [pcf_pkg::VAL_W-1:0] v);
        trim_down = (v < pcf_pkg::OUT_MIN + pcf_pkg::ADJ_STEP) ? pcf_pkg::OUT_MIN : v - pcf_pkg::ADJ_STEP;
    endfunction : trim_down

    ////////////////////////////////////////////////////////////////////////////
    // Output selection.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
        begin
            out_sel <= pcf_pkg::PCF_OUT_LIVE;
            prog_active <= 1'b0;
            current_invert <= 1'b0;
        end
        else
        begin
            prog_active <= (mode != pcf_pkg::PCF_NORMAL);
            current_invert <= cal.invert && cur_variant; // [R13]
            if (both && mode != pcf_pkg::PCF_NORMAL)
                out_sel <= pcf_pkg::PCF_OUT_ERROR; // [R12] [R14]
            else if (ind_hold && press && mode == pcf_pkg::PCF_TEACH)
                out_sel <= pcf_pkg::PCF_OUT_TEACH_IND; // [R6]
            else if (ind_hold && press && mode == pcf_pkg::PCF_ADJUST)
                out_sel <= pcf_pkg::PCF_OUT_ADJ_IND; // [R18]
            else
                out_sel <= pcf_pkg::PCF_OUT_LIVE; // [R7]
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register port: software sets the variant and reads state and calibration, but never writes calibration.
    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            cur_variant <= pcf_pkg::CUR_VARIANT_RST;
        else if (reg_wr && reg_addr == pcf_pkg::REG_CTRL)
            cur_variant <= reg_wdata[pcf_pkg::CTRL_CUR_VARIANT];
    end

    always_ff @(posedge mclk or posedge rst)
    begin
        if (rst)
            reg_rdata <= '0;
        else if (reg_rd)
        begin
            unique case (reg_addr)
                pcf_pkg::REG_CTRL: reg_rdata <= {31'h0, cur_variant};
                pcf_pkg::REG_STATUS: reg_rdata <= {26'h0, inv_pend, cal.invert, out_sel, mode};
                pcf_pkg::REG_NULL: reg_rdata <= {16'h0, cal.null_pt};
                pcf_pkg::REG_END: reg_rdata <= {16'h0, cal.end_pt};
                pcf_pkg::REG_START_VAL: reg_rdata <= {16'h0, cal.start_val};
                pcf_pkg::REG_END_VAL: reg_rdata <= {16'h0, cal.end_val};
                default: reg_rdata <= '0;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);

    a_teach_entry: assert property (mode == pcf_pkg::PCF_NORMAL && fire_entry && a_only |=> mode == pcf_pkg::PCF_TEACH ##1 out_sel == pcf_pkg::PCF_OUT_TEACH_IND) else $error("teach entry missed"); // [R6]
    a_adjust_entry: assert property (mode == pcf_pkg::PCF_NORMAL && fire_entry && b_only |=> mode == pcf_pkg::PCF_ADJUST) else $error("adjust entry missed"); // [R18]
    a_live_release: assert property (mode != pcf_pkg::PCF_NORMAL && !press |=> out_sel == pcf_pkg::PCF_OUT_LIVE) else $error("live value not restored"); // [R7]
    a_null_capture: assert property (mode == pcf_pkg::PCF_TEACH && !ind_hold && fire_cap && a_only |=> cal.null_pt == $past(position) && $stable(cal.end_pt)) else $error("null capture wrong"); // [R8]
    a_end_capture: assert property (mode == pcf_pkg::PCF_TEACH && !ind_hold && fire_cap && b_only |=> cal.end_pt == $past(position) && $stable(cal.null_pt)) else $error("end capture wrong"); // [R9]
    a_invert_release: assert property (inv_pend && release_ev |=> cal.invert != $past(cal.invert) ##1 current_invert == (cal.invert && cur_variant)) else $error("inversion not applied"); // [R11]
    a_error_both: assert property (both && mode == pcf_pkg::PCF_TEACH |=> out_sel == pcf_pkg::PCF_OUT_ERROR) else $error("error value absent"); // [R12]
    a_short_exit: assert property (mode == pcf_pkg::PCF_TEACH && short_both && !timeout |=> mode == pcf_pkg::PCF_NORMAL ##2 out_sel == pcf_pkg::PCF_OUT_LIVE) else $error("teach not ended"); // [R14]
    a_reset_done: assert property (mode == pcf_pkg::PCF_RESET && fire_entry && both && !timeout |=> cal == pcf_pkg::CAL_FACTORY && mode == pcf_pkg::PCF_NORMAL) else $error("reset incomplete"); // [R20]
    a_reset_abort: assert property (mode == pcf_pkg::PCF_RESET && short_both |=> mode == pcf_pkg::PCF_NORMAL && $stable(cal)) else $error("abort changed values"); // [R21]
    a_idle_exit: assert property (timeout |=> mode == pcf_pkg::PCF_NORMAL && $stable(cal)) else $error("timeout exit wrong"); // [R2]

    c_teach: cover property (mode == pcf_pkg::PCF_NORMAL ##1 mode == pcf_pkg::PCF_TEACH);
    c_invert: cover property (inv_pend && release_ev);
    c_reset: cover property (mode == pcf_pkg::PCF_RESET && fire_entry && both);
    c_trim: cover property (mode == pcf_pkg::PCF_ADJUST && short_b);
endmodule : pcf_calib
`default_nettype wire

// *** pcf_box_model.sv ***
// Behavioural calibration box that drives the two programming lines.
`timescale 1ns/100ps
`default_nettype none
module pcf_box_model #(
    parameter int TICK_CYC = 4
) (
    input wire logic mclk,
    output logic program_input_a,
    output logic program_input_b
);
    // A released line falls to the pull-down level of the input, so idle is low.
    initial
    begin
        program_input_a = 1'b0;
        program_input_b = 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // Both lines move on one edge, so a both command never begins as a single press.
    task automatic press(input logic a, input logic b);
        @(posedge mclk);
        program_input_a <= a;
        program_input_b <= b;
    endtask : press
    task automatic release_lines();
        @(posedge mclk);
        program_input_a <= 1'b0;
        program_input_b <= 1'b0;
    endtask : release_lines
    // The box only holds lines; scenarios pick points in order and inside the span.
    task automatic hold(input logic a, input logic b, input int ticks);
        press(a, b);
        repeat (ticks * TICK_CYC) @(posedge mclk);
        release_lines();
    endtask : hold
endmodule : pcf_box_model
`default_nettype wire

// *** pcf_calib_tb_top.sv ***
// Self-checking testbench of the programming input calibration controller.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end
module pcf_calib_tb_top;
    localparam int TC = 4;
    logic mclk;
    logic rst;
    logic program_input_a;
    logic program_input_b;
    logic [15:0] position;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic reg_wr;
    logic reg_rd;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    pcf_pkg::pcf_out_sel_t out_sel;
    pcf_pkg::pcf_cal_t cal;
    logic current_invert;
    logic prog_active;
    int failures = 0;
    int compares = 0;
    initial mclk = 1'b0;
    always #12.5 mclk = ~mclk;
    // Short counts keep the run small; they keep short < capture < entry < idle.
    pcf_calib #(.TICK_CYC(TC), .IDLE_TICKS(200), .ENTRY_TICKS(40), .CAPTURE_TICKS(20),
        .SHORT_TICKS(10), .DEBOUNCE_TICKS(2)) dut_u (.mclk(mclk), .rst(rst),
        .program_input_a(program_input_a), .program_input_b(program_input_b), .position(position),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .out_sel(out_sel), .cal(cal), .current_invert(current_invert),
        .prog_active(prog_active));
    pcf_box_model #(.TICK_CYC(TC)) box_u (.mclk(mclk), .program_input_a(program_input_a),
        .program_input_b(program_input_b));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Checks made %0d, mismatches %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    task automatic ticks(input int n);
        repeat (n * TC) @(posedge mclk);
        #1;
    endtask : ticks
    task automatic wait_sel(input pcf_pkg::pcf_out_sel_t exp, input int lim);
        int n;
        n = 0;
        while (out_sel !== exp && n < lim)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        `CHK("out_sel", exp, out_sel)
        if (n >= lim)
            conclude();
    endtask : wait_sel
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask : reg_write
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_values();
        `CHK("cal", pcf_pkg::CAL_FACTORY, cal)
        `CHK("prog_active", 1'b0, prog_active)
        reg_read(pcf_pkg::REG_CTRL, rd);
        `CHK("ctrl", 32'h00000001, rd)
        reg_read(8'h20, rd);
        `CHK("unmapped", 32'h00000000, rd)
        // A bus write must not bypass the programming lines.
        reg_write(pcf_pkg::REG_NULL, 32'h00001111);
        ticks(1);
        `CHK("null_pt", 16'h0000, cal.null_pt)
    endtask : t_reset_values
    task automatic t_teach_entry();
        box_u.press(1'b1, 1'b0);
        ticks(45);
        wait_sel(pcf_pkg::PCF_OUT_TEACH_IND, 40);
        reg_read(pcf_pkg::REG_STATUS, rd);
        `CHK("mode", 2'h1, rd[1:0])
        box_u.release_lines();
        wait_sel(pcf_pkg::PCF_OUT_LIVE, 20 * TC);
        `CHK("prog_active", 1'b1, prog_active)
    endtask : t_teach_entry
    task automatic t_capture();
        position <= 16'h1234;
        box_u.hold(1'b1, 1'b0, 25);
        ticks(5);
        `CHK("null_pt", 16'h1234, cal.null_pt)
        `CHK("end_pt", 16'hFFFF, cal.end_pt)
        position <= 16'h8000;
        box_u.hold(1'b0, 1'b1, 25);
        ticks(5);
        `CHK("end_pt", 16'h8000, cal.end_pt)
        `CHK("null_pt", 16'h1234, cal.null_pt)
    endtask : t_capture
    task automatic t_invert();
        box_u.press(1'b1, 1'b1);
        ticks(45);
        `CHK("out_sel", pcf_pkg::PCF_OUT_ERROR, out_sel)
        `CHK("invert", 1'b0, cal.invert)
        box_u.release_lines();
        ticks(5);
        `CHK("invert", 1'b1, cal.invert)
        `CHK("current_invert", 1'b1, current_invert)
        reg_write(pcf_pkg::REG_CTRL, 32'h00000000);
        ticks(1);
        `CHK("current_invert", 1'b0, current_invert)
        reg_write(pcf_pkg::REG_CTRL, 32'h00000001);
    endtask : t_invert
    task automatic t_short_end();
        box_u.press(1'b1, 1'b1);
        ticks(5);
        `CHK("out_sel", pcf_pkg::PCF_OUT_ERROR, out_sel)
        box_u.release_lines();
        ticks(5);
        `CHK("prog_active", 1'b0, prog_active)
        `CHK("out_sel", pcf_pkg::PCF_OUT_LIVE, out_sel)
        `CHK("null_pt", 16'h1234, cal.null_pt)
        `CHK("invert", 1'b1, cal.invert)
    endtask : t_short_end
    task automatic t_adjust_idle();
        box_u.press(1'b0, 1'b1);
        ticks(45);
        wait_sel(pcf_pkg::PCF_OUT_ADJ_IND, 40);
        box_u.release_lines();
        wait_sel(pcf_pkg::PCF_OUT_LIVE, 20 * TC);
        position <= 16'h2000;
        box_u.hold(1'b1, 1'b0, 25);
        ticks(5);
        `CHK("start point", 16'h2000, cal.null_pt)
        `CHK("start_val", 16'h0000, cal.start_val)
        box_u.hold(1'b0, 1'b1, 5);
        ticks(5);
        `CHK("start_val", pcf_pkg::ADJ_STEP, cal.start_val)
        // Two steps down from one step up must stop at the output limit.
        box_u.hold(1'b1, 1'b0, 5);
        ticks(5);
        box_u.hold(1'b1, 1'b0, 5);
        ticks(5);
        `CHK("start_val", pcf_pkg::OUT_MIN, cal.start_val)
        `CHK("prog_active", 1'b1, prog_active)
        ticks(210);
        `CHK("prog_active", 1'b0, prog_active)
        `CHK("start point", 16'h2000, cal.null_pt)
    endtask : t_adjust_idle
    task automatic t_reset_seq();
        box_u.hold(1'b1, 1'b1, 45);
        ticks(5);
        reg_read(pcf_pkg::REG_STATUS, rd);
        `CHK("mode", 2'h3, rd[1:0])
        box_u.hold(1'b1, 1'b1, 5);
        ticks(5);
        `CHK("prog_active", 1'b0, prog_active)
        `CHK("null_pt", 16'h2000, cal.null_pt)
        box_u.hold(1'b1, 1'b1, 45);
        ticks(5);
        box_u.hold(1'b1, 1'b1, 45);
        ticks(5);
        `CHK("cal", pcf_pkg::CAL_FACTORY, cal)
        `CHK("out_sel", pcf_pkg::PCF_OUT_LIVE, out_sel)
        `CHK("prog_active", 1'b0, prog_active)
    endtask : t_reset_seq
    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        rst = 1'b1;
        position = 16'h0000;
        reg_addr = 8'h00;
        reg_wdata = 32'h00000000;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        ticks(1);
        t_reset_values();
        t_teach_entry();
        t_capture();
        t_invert();
        t_short_end();
        t_adjust_idle();
        t_reset_seq();
        conclude();
    end
    // A hang anywhere ends the run as a failure.
    initial
    begin
        repeat (90000) @(posedge mclk);
        failures++;
        conclude();
    end
endmodule : pcf_calib_tb_top
`default_nettype wire
